/* File: rtl/tdc_top.sv */
// two-channel capture/compare setup block with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "tdc_regs.svh"
// ----------------------------------------------------------------------------
// Overview of operation
// - channel 1 direction bits 1:0: output, input one, input two, trigger source
// - direction fields change only while that channel's enable bit is zero
// - channel 2 direction bits 9:8 with the same source mapping
// - channel 1 capture every 1, 2, 4 or 8 events from bits 3:2
// - filter code 0000 passes the input sampled at the kernel clock
// - other filter codes pick sampling divider and stable sample count
// - channel 2 prescaler bits 11:10 and filter bits 15:12, same coding
// - output channel: enable bit 0 drives or releases the output pin
// - input channel: enable bit 0 permits counter capture on events
// - output channel: polarity bit 1 makes the pin active low
// - input polarity 00 rising, 01 falling, 10 reserved
// - polarity 11 captures both edges; not for encoder mode
// - output mode: buffer enable bit 3, compare mode bits 6:4
// - buffered compare value loads at update event, else immediately
// - compare modes freeze, set, clear, toggle, force low/high, pwm 1/2
// ----------------------------------------------------------------------------
module tdc_top #(
   parameter int CNT_W  = 16,
   parameter int ADDR_W = 8
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   input  wire logic              timer_input_one,
   input  wire logic              timer_input_two,
   input  wire logic              internal_trigger_source,
   input  wire logic [CNT_W-1:0]  counter_value,
   input  wire logic              update_event,
   output var  logic              ch1_output_pin,
   output var  logic              ch1_output_oe,
   output var  logic              ch2_output_pin,
   output var  logic              ch2_output_oe,
   output var  logic              ch1_capture_pulse,
   output var  logic              ch2_capture_pulse
);
   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
      $error("CNT_W must lie between 2 and 16");
   end
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 8 and 32");
   end

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [15:0]          mode_r;
   logic [15:0]          enpol_r;
   logic [31:0]          prdata_r;
   logic                 pready_r;
   logic                 pslverr_r;
   logic [CNT_W-1:0]     cmp_wr_r  [2];
   logic [CNT_W-1:0]     cmp_act_r [2];
   logic [1:0]           ref_r;
   logic [1:0]           pin_r;
   logic [1:0]           oe_r;
   logic [1:0]           filt_prev_r;
   logic                 trg_prev_r;
   tdc_pkg::tdc_dir_t    dir_v [2];
   tdc_pkg::tdc_ocm_t    ocm_v [2];
   logic [1:0]           out_v;
   logic [1:0]           en_v;
   logic [1:0]           pol_v;
   logic [1:0]           npol_v;
   logic [1:0]           buf_v;
   logic [1:0]           raw_v;
   logic [1:0]           filt_v;
   logic [1:0]           evt_v;
   logic [1:0]           wr_cmp;
   logic [CNT_W-1:0]     cap_val [2];
   logic                 trg_rise;
   logic                 acc;
   logic                 wr;
   logic                 wr_mode;
   logic                 wr_enpol;
   logic [31:0]          rd_mux;
   logic [15:0]          mode_nxt;

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a == ADDR_W'(`TDC_OFF_MODE)) || (a == ADDR_W'(`TDC_OFF_ENPOL)) ||
                (a == ADDR_W'(`TDC_OFF_CH1_VAL)) || (a == ADDR_W'(`TDC_OFF_CH2_VAL));
   endfunction

   function automatic logic sel_raw(input tdc_pkg::tdc_dir_t d, input logic a, input logic b);
      case (d)
         tdc_pkg::TDC_DIR_TI_A: sel_raw = a;
         tdc_pkg::TDC_DIR_TI_B: sel_raw = b;
         default:               sel_raw = 1'b0;
      endcase
   endfunction

   function automatic logic edge_evt(input logic [1:0] code, input logic cur, input logic prev);
      case (tdc_pkg::tdc_edge_t'(code))
         tdc_pkg::TDC_EDGE_RISE: edge_evt = cur && !prev;
         tdc_pkg::TDC_EDGE_FALL: edge_evt = !cur && prev;
         tdc_pkg::TDC_EDGE_BOTH: edge_evt = cur ^ prev;
         default:                edge_evt = cur && !prev;
      endcase
   endfunction

   function automatic logic ref_calc(input tdc_pkg::tdc_ocm_t m, input logic r,
                                     input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
      case (m)
         tdc_pkg::TDC_OCM_SET:  ref_calc = (cnt == cmp) ? 1'b1 : r;
         tdc_pkg::TDC_OCM_CLR:  ref_calc = (cnt == cmp) ? 1'b0 : r;
         tdc_pkg::TDC_OCM_TGL:  ref_calc = (cnt == cmp) ? !r : r;
         tdc_pkg::TDC_OCM_FLO:  ref_calc = 1'b0;
         tdc_pkg::TDC_OCM_FHI:  ref_calc = 1'b1;
         tdc_pkg::TDC_OCM_PWM1: ref_calc = (cnt < cmp);
         tdc_pkg::TDC_OCM_PWM2: ref_calc = (cnt > cmp);
         default:               ref_calc = r;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------------
   assign dir_v[0]  = tdc_pkg::tdc_dir_t'(mode_r[`TDC_C1_DIR]);
   assign dir_v[1]  = tdc_pkg::tdc_dir_t'(mode_r[`TDC_C2_DIR]);
   assign ocm_v[0]  = tdc_pkg::tdc_ocm_t'(mode_r[`TDC_C1_OCM]);
   assign ocm_v[1]  = tdc_pkg::tdc_ocm_t'(mode_r[`TDC_C2_OCM]);
   assign buf_v     = {mode_r[`TDC_C2_BUF], mode_r[`TDC_C1_BUF]};
   assign en_v      = {enpol_r[`TDC_C2_EN], enpol_r[`TDC_C1_EN]};
   assign pol_v     = {enpol_r[`TDC_C2_POL], enpol_r[`TDC_C1_POL]};
   assign npol_v    = {enpol_r[`TDC_C2_NPOL], enpol_r[`TDC_C1_NPOL]};
   assign out_v[0]  = (dir_v[0] == tdc_pkg::TDC_DIR_OUT);
   assign out_v[1]  = (dir_v[1] == tdc_pkg::TDC_DIR_OUT);
   assign raw_v[0]  = sel_raw(dir_v[0], timer_input_one, timer_input_two);
   assign raw_v[1]  = sel_raw(dir_v[1], timer_input_one, timer_input_two);
   assign trg_rise  = internal_trigger_source && !trg_prev_r;

   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   assign acc      = psel && penable && pready_r;
   assign wr       = acc && pwrite && !pslverr_r;
   assign wr_mode  = wr && (paddr == ADDR_W'(`TDC_OFF_MODE));
   assign wr_enpol = wr && (paddr == ADDR_W'(`TDC_OFF_ENPOL));
   assign wr_cmp[0] = wr && (paddr == ADDR_W'(`TDC_OFF_CH1_VAL)) && out_v[0];
   assign wr_cmp[1] = wr && (paddr == ADDR_W'(`TDC_OFF_CH2_VAL)) && out_v[1];

   always_comb begin
      case (paddr)
         ADDR_W'(`TDC_OFF_MODE):    rd_mux = {16'h0000, mode_r};
         ADDR_W'(`TDC_OFF_ENPOL):   rd_mux = {16'h0000, enpol_r};
         ADDR_W'(`TDC_OFF_CH1_VAL): rd_mux = 32'(out_v[0] ? cmp_wr_r[0] : cap_val[0]);
         ADDR_W'(`TDC_OFF_CH2_VAL): rd_mux = 32'(out_v[1] ? cmp_wr_r[1] : cap_val[1]);
         default:                   rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel && !penable;
         pslverr_r <= psel && !penable && !addr_ok(paddr);
         prdata_r  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // mode and enable registers
   // ----------------------------------------------------------------------
   always_comb begin
      mode_nxt = pwdata[15:0];
      if (en_v[0]) begin
         mode_nxt[`TDC_C1_DIR] = mode_r[`TDC_C1_DIR];
      end
      if (en_v[1]) begin
         mode_nxt[`TDC_C2_DIR] = mode_r[`TDC_C2_DIR];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= `TDC_MODE_RST;
      end else if (wr_mode) begin
         mode_r <= mode_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enpol_r <= `TDC_ENPOL_RST;
      end else if (wr_enpol) begin
         enpol_r <= pwdata[15:0] & `TDC_ENPOL_MASK;
      end
   end

   // ----------------------------------------------------------------------
   // input paths: filter, polarity, edge, capture
   // ----------------------------------------------------------------------
   tdc_in_filter u_flt1 (
      .pclk    (pclk),
      .presetn (presetn),
      .code    (mode_r[`TDC_C1_FLT]),
      .d       (raw_v[0]),
      .q_r     (filt_v[0])
   );
   tdc_in_filter u_flt2 (
      .pclk    (pclk),
      .presetn (presetn),
      .code    (mode_r[`TDC_C2_FLT]),
      .d       (raw_v[1]),
      .q_r     (filt_v[1])
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_prev_r <= 2'h0;
         trg_prev_r  <= 1'b0;
      end else begin
         filt_prev_r <= filt_v;
         trg_prev_r  <= internal_trigger_source;
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (dir_v[i] == tdc_pkg::TDC_DIR_TRG) begin
            evt_v[i] = trg_rise;
         end else begin
            evt_v[i] = edge_evt({npol_v[i], pol_v[i]}, filt_v[i], filt_prev_r[i]);
         end
      end
   end

   tdc_cap_chan #(.CNT_W(CNT_W)) u_cap1 (
      .pclk          (pclk),
      .presetn       (presetn),
      .evt           (evt_v[0]),
      .cap_en        (!out_v[0] && en_v[0]),
      .psc           (mode_r[`TDC_C1_PSC]),
      .counter_value (counter_value),
      .cap_val_r     (cap_val[0]),
      .cap_pulse_r   (ch1_capture_pulse)
   );
   tdc_cap_chan #(.CNT_W(CNT_W)) u_cap2 (
      .pclk          (pclk),
      .presetn       (presetn),
      .evt           (evt_v[1]),
      .cap_en        (!out_v[1] && en_v[1]),
      .psc           (mode_r[`TDC_C2_PSC]),
      .counter_value (counter_value),
      .cap_val_r     (cap_val[1]),
      .cap_pulse_r   (ch2_capture_pulse)
   );

   // ----------------------------------------------------------------------
   // compare values
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            cmp_wr_r[i]  <= '0;
            cmp_act_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_cmp[i]) begin
               cmp_wr_r[i] <= pwdata[CNT_W-1:0];
            end
            if (wr_cmp[i] && !buf_v[i]) begin
               cmp_act_r[i] <= pwdata[CNT_W-1:0];
            end else if (update_event && buf_v[i]) begin
               cmp_act_r[i] <= cmp_wr_r[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // output reference and pins
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (out_v[i]) begin
               ref_r[i] <= ref_calc(ocm_v[i], ref_r[i], counter_value, cmp_act_r[i]);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_r  <= 2'h0;
         pin_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            oe_r[i]  <= out_v[i] && en_v[i];
            pin_r[i] <= (out_v[i] && en_v[i]) ? (ref_r[i] ^ pol_v[i]) : 1'b0;
         end
      end
   end

   assign ch1_output_pin = pin_r[0];
   assign ch1_output_oe  = oe_r[0];
   assign ch2_output_pin = pin_r[1];
   assign ch2_output_oe  = oe_r[1];
   assign prdata         = prdata_r;
   assign pready         = pready_r;
   assign pslverr        = pslverr_r;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   sequence s_apb_setup;
      psel && !penable;
   endsequence
   sequence s_apb_answer;
      pready_r && psel && penable;
   endsequence
   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn) s_apb_setup ##1 penable |-> s_apb_answer;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("no ready in first access cycle");
   property p_dir_locked;
      @(posedge pclk) disable iff (!presetn) (wr_mode && en_v[0]) |=> $stable(mode_r[`TDC_C1_DIR]);
   endproperty
   a_dir_locked: assert property (p_dir_locked) else $error("direction changed while enabled");
   property p_dir_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_mode && !en_v[1]) |=> (mode_r[`TDC_C2_DIR] == $past(pwdata[`TDC_C2_DIR]));
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");
   property p_oe_on;
      @(posedge pclk) disable iff (!presetn) (out_v[0] && en_v[0]) |=> ch1_output_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("enabled output not driven");
   property p_oe_off;
      @(posedge pclk) disable iff (!presetn) !en_v[0] |=> !ch1_output_oe && !ch1_output_pin;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("disabled output still driven");
   property p_pin_pol;
      @(posedge pclk) disable iff (!presetn) ch1_output_oe |-> (ch1_output_pin == ($past(ref_r[0]) ^ $past(pol_v[0])));
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("output polarity wrong");
   property p_cmp_direct;
      @(posedge pclk) disable iff (!presetn)
         (wr_cmp[0] && !buf_v[0]) |=> (cmp_act_r[0] == $past(pwdata[CNT_W-1:0]));
   endproperty
   a_cmp_direct: assert property (p_cmp_direct) else $error("unbuffered compare not immediate");
   property p_cmp_buffered;
      @(posedge pclk) disable iff (!presetn) (buf_v[0] && !update_event) |=> $stable(cmp_act_r[0]);
   endproperty
   a_cmp_buffered: assert property (p_cmp_buffered) else $error("buffered compare loaded early");
   property p_force_low;
      @(posedge pclk) disable iff (!presetn) (out_v[1] && ocm_v[1] == tdc_pkg::TDC_OCM_FLO) |=> !ref_r[1];
   endproperty
   a_force_low: assert property (p_force_low) else $error("forced low reference not low");
   property p_rise_capture;
      @(posedge pclk) disable iff (!presetn)
         (!out_v[0] && en_v[0] && dir_v[0] != tdc_pkg::TDC_DIR_TRG && {npol_v[0], pol_v[0]} == 2'h1
          && filt_v[0] && !filt_prev_r[0]) |-> !evt_v[0];
   endproperty
   a_rise_capture: assert property (p_rise_capture) else $error("inverted input took a rising edge");
endmodule  // tdc_top
`default_nettype wire

/* File: rtl/tdc_regs.svh */
// register offsets, field positions and reset values of the capture/compare block
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH
`define TDC_OFF_MODE     8'h18
`define TDC_OFF_ENPOL    8'h20
`define TDC_OFF_CH1_VAL  8'h34
`define TDC_OFF_CH2_VAL  8'h38
`define TDC_MODE_RST     16'h0000
`define TDC_ENPOL_RST    16'h0000
`define TDC_ENPOL_MASK   16'h00BF
`define TDC_C1_DIR       1:0
`define TDC_C1_PSC       3:2
`define TDC_C1_FLT       7:4
`define TDC_C1_BUF       3
`define TDC_C1_OCM       6:4
`define TDC_C2_DIR       9:8
`define TDC_C2_PSC       11:10
`define TDC_C2_FLT       15:12
`define TDC_C2_BUF       11
`define TDC_C2_OCM       14:12
`define TDC_C1_EN        0
`define TDC_C1_POL       1
`define TDC_C1_NPOL      3
`define TDC_C2_EN        4
`define TDC_C2_POL       5
`define TDC_C2_NPOL      7
`define TDC_FLT_OFF      4'h0
`endif

/* File: rtl/tdc_pkg.sv */
// types shared by the capture/compare block
package tdc_pkg;
   typedef enum logic [1:0] {
      TDC_DIR_OUT  = 2'h0,
      TDC_DIR_TI_A = 2'h1,
      TDC_DIR_TI_B = 2'h2,
      TDC_DIR_TRG  = 2'h3
   } tdc_dir_t;
   typedef enum logic [2:0] {
      TDC_OCM_FRZ  = 3'h0,
      TDC_OCM_SET  = 3'h1,
      TDC_OCM_CLR  = 3'h2,
      TDC_OCM_TGL  = 3'h3,
      TDC_OCM_FLO  = 3'h4,
      TDC_OCM_FHI  = 3'h5,
      TDC_OCM_PWM1 = 3'h6,
      TDC_OCM_PWM2 = 3'h7
   } tdc_ocm_t;
   typedef enum logic [1:0] {
      TDC_EDGE_RISE = 2'h0,
      TDC_EDGE_FALL = 2'h1,
      TDC_EDGE_RSVD = 2'h2,
      TDC_EDGE_BOTH = 2'h3
   } tdc_edge_t;
endpackage

/* File: rtl/tdc_in_filter.sv */
// digital input filter with sampling divider and sample count
`timescale 1ns/1ps
`default_nettype none
`include "tdc_regs.svh"
module tdc_in_filter (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] code,
   input  wire logic       d,
   output var  logic       q_r
);
   logic [4:0] div_cnt_r;
   logic [3:0] run_r;
   logic [4:0] div_m1;
   logic [3:0] n_m1;
   logic       sample_en;

   // code to divider-1 and count-1
   function automatic logic [8:0] flt_decode(input logic [3:0] c);
      case (c)
         4'h1: flt_decode = {5'h00, 4'h1};
         4'h2: flt_decode = {5'h00, 4'h3};
         4'h3: flt_decode = {5'h00, 4'h7};
         4'h4: flt_decode = {5'h01, 4'h5};
         4'h5: flt_decode = {5'h01, 4'h7};
         4'h6: flt_decode = {5'h03, 4'h5};
         4'h7: flt_decode = {5'h03, 4'h7};
         4'h8: flt_decode = {5'h07, 4'h5};
         4'h9: flt_decode = {5'h07, 4'h7};
         4'hA: flt_decode = {5'h0F, 4'h4};
         4'hB: flt_decode = {5'h0F, 4'h5};
         4'hC: flt_decode = {5'h0F, 4'h7};
         4'hD: flt_decode = {5'h1F, 4'h4};
         4'hE: flt_decode = {5'h1F, 4'h5};
         4'hF: flt_decode = {5'h1F, 4'h7};
         default: flt_decode = {5'h00, 4'h0};
      endcase
   endfunction

   assign {div_m1, n_m1} = flt_decode(code);
   assign sample_en = (div_cnt_r == div_m1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 5'h00;
      end else if (code == `TDC_FLT_OFF || sample_en) begin
         div_cnt_r <= 5'h00;
      end else begin
         div_cnt_r <= div_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r   <= 1'b0;
         run_r <= 4'h0;
      end else if (code == `TDC_FLT_OFF) begin
         q_r   <= d;
         run_r <= 4'h0;
      end else if (sample_en) begin
         if (d == q_r) begin
            run_r <= 4'h0;
         end else if (run_r == n_m1) begin
            q_r   <= d;
            run_r <= 4'h0;
         end else begin
            run_r <= run_r + 4'h1;
         end
      end
   end

   property p_flt_bypass;
      @(posedge pclk) disable iff (!presetn) (code == `TDC_FLT_OFF) |=> (q_r == $past(d));
   endproperty
   a_flt_bypass: assert property (p_flt_bypass) else $error("unfiltered input not passed through");
   property p_flt_hold;
      @(posedge pclk) disable iff (!presetn) (code != `TDC_FLT_OFF && !sample_en) |=> $stable(q_r);
   endproperty
   a_flt_hold: assert property (p_flt_hold) else $error("filter output moved between samples");
endmodule  // tdc_in_filter
`default_nettype wire

/* File: rtl/tdc_cap_chan.sv */
// capture event prescaler and capture value register of one channel
`timescale 1ns/1ps
`default_nettype none
module tdc_cap_chan #(
   parameter int CNT_W = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             evt,
   input  wire logic             cap_en,
   input  wire logic [1:0]       psc,
   input  wire logic [CNT_W-1:0] counter_value,
   output var  logic [CNT_W-1:0] cap_val_r,
   output var  logic             cap_pulse_r
);
   logic [2:0] evt_cnt_r;
   logic [2:0] ratio_m1;
   logic       take;

   assign ratio_m1 = 3'((4'h1 << psc) - 4'h1);
   assign take     = cap_en && evt && (evt_cnt_r >= ratio_m1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_cnt_r <= 3'h0;
      end else if (!cap_en) begin
         evt_cnt_r <= 3'h0;
      end else if (take) begin
         evt_cnt_r <= 3'h0;
      end else if (evt) begin
         evt_cnt_r <= evt_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_val_r   <= '0;
         cap_pulse_r <= 1'b0;
      end else begin
         cap_pulse_r <= take;
         if (take) begin
            cap_val_r <= counter_value;
         end
      end
   end

   property p_cap_value;
      @(posedge pclk) disable iff (!presetn) cap_pulse_r |-> (cap_val_r == $past(counter_value));
   endproperty
   a_cap_value: assert property (p_cap_value) else $error("captured value is not the counter");
   property p_psc_restart;
      @(posedge pclk) disable iff (!presetn) !cap_en |=> (evt_cnt_r == 3'h0) && !cap_pulse_r;
   endproperty
   a_psc_restart: assert property (p_psc_restart) else $error("prescaler not cleared while disabled");
endmodule  // tdc_cap_chan
`default_nettype wire

/* File: testbench/tdc_pin_model.sv */
// model of the signals that reach the timer input pins
`timescale 1ns/1ps
`default_nettype none
module tdc_pin_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic go,
   output var  logic pin_one,
   output var  logic pin_two
);
   logic [2:0] cnt_r;
   // pulse of four cycles on go; unused pin keeps moving
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r   <= 3'h0;
         pin_one <= 1'b0;
         pin_two <= 1'b0;
      end else begin
         pin_two <= ~pin_two;
         pin_one <= go || (cnt_r > 3'h1);
         cnt_r   <= go ? 3'h4 : (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
      end
   end
endmodule // tdc_pin_model
`default_nettype wire

/* File: testbench/tdc_top_tb.sv */
// self-checking bench of the capture/compare block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
   $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module tdc_top_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, in_one, in_two, p1, oe1;
   logic [15:0] cv = 16'h0000;
   int          n_errors = 0, compares = 0, caps = 0, caps2 = 0;
   logic        cp1, cp2, p2, oe2, trg = 1'b0, upd = 1'b0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) if (cp1 === 1'b1) caps++;
   always @(posedge pclk) if (cp2 === 1'b1) caps2++;
   tdc_pin_model u_tdc_pin_model (.pclk(pclk), .presetn(presetn), .go(go), .pin_one(in_one), .pin_two(in_two));
   tdc_top u_tdc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_input_one(in_one), .timer_input_two(in_two), .internal_trigger_source(trg),
      .counter_value(cv), .update_event(upd), .ch1_output_pin(p1), .ch1_output_oe(oe1),
      .ch2_output_pin(p2), .ch2_output_oe(oe2), .ch1_capture_pulse(cp1), .ch2_capture_pulse(cp2));
   // ----------------------------------------------------------------
   // apb master and closing
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int k;
      k = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k >= 20) begin n_errors++; test_done(); end
      @(posedge pclk);
   endtask
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, 8'h20, 16'h0); `CHK(rd, 32'h0)
      apb(1'b0, 8'h40, 16'h0); `CHK(err, 1'b1)
   endtask
   task automatic t_capture();
      apb(1'b1, 8'h18, 16'h0005);
      apb(1'b1, 8'h20, 16'h0001);
      apb(1'b1, 8'h18, 16'h000A);
      apb(1'b0, 8'h18, 16'h0); `CHK(rd, 32'h0009)
      for (int i = 0; i < 4; i++) begin
         cv <= 16'h1000 + 16'(i); go <= 1'b1;
         @(posedge pclk); go <= 1'b0;
         repeat (12) @(posedge pclk);
      end
      `CHK(caps, 1)
      apb(1'b0, 8'h34, 16'h0); `CHK(rd, 32'h1003)
   endtask
   task automatic t_output();
      apb(1'b1, 8'h20, 16'h0000);
      apb(1'b1, 8'h18, 16'h0050);
      apb(1'b1, 8'h20, 16'h0001);
      repeat (3) @(posedge pclk);
      `CHK({oe1, p1}, 2'b11)
      apb(1'b1, 8'h20, 16'h0003);
      repeat (3) @(posedge pclk);
      `CHK({oe1, p1}, 2'b10)
   endtask
   // ch2 on input one, filter code 1, falling edge; capture must see the late counter value
   task automatic t_chan2();
      apb(1'b1, 8'h18, 16'h1150);
      apb(1'b1, 8'h20, 16'h0033);
      cv <= 16'h2000; go <= 1'b1;
      @(posedge pclk); go <= 1'b0;
      repeat (4) @(posedge pclk);
      cv <= 16'h2222;
      repeat (8) @(posedge pclk);
      `CHK(caps2, 1)
      `CHK({oe2, p2}, 2'b00)
      apb(1'b0, 8'h38, 16'h0); `CHK(rd, 32'h2222)
   endtask
   // ch2 on trigger source; ch1 pwm 1 with buffered compare value
   task automatic t_buffer();
      apb(1'b1, 8'h20, 16'h0003);
      apb(1'b1, 8'h18, 16'h0368);
      apb(1'b1, 8'h20, 16'h0013);
      trg <= 1'b1;
      @(posedge pclk); trg <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(caps2, 2)
      apb(1'b1, 8'h34, 16'h3000);
      repeat (3) @(posedge pclk);
      `CHK({oe1, p1}, 2'b11)
      upd <= 1'b1;
      @(posedge pclk); upd <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK({oe1, p1}, 2'b10)
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_capture();
      t_output();
      t_chan2();
      t_buffer();
      test_done();
   end
endmodule // tdc_top_tb
`default_nettype wire
